//--- core/nvm_access_control.sv
// What this block does
// RULE_01: Top select bit picks flash, else EEPROM.
// RULE_02: Bit six selects configuration space when set.
// RULE_03: Row-erase bit makes next write erase block.
// RULE_04: Cut-short or improper write sets error flag.
// RULE_05: Erase/write start only while write permit set.
// RULE_06: Write start self-times; hardware clears, software sets.
// RULE_07: Read start completes in one cycle, self-clears.
// RULE_08: Read refused while either select bit set.
// RULE_09: Host loads address, data, permit before starting.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "nvm_map.svh"

module nvm_access_control
    import nvm_pkg::*;
#(
    parameter int WRITE_CYCLES = `NVM_WRITE_CYCLES
) (
    input wire logic ref_clk, // System clock, 125 MHz
    input wire logic rst_b, // Power-on reset, async
    input wire logic warm_rst, // Other device resets, sync level
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output nvm_cmd_t nvm_cmd, // Command to the memory arrays
    input wire logic [`NVM_DATA_W-1:0] nvm_rdata, // Array read data, same cycle
    output logic irq // Level interrupt
);

    if (WRITE_CYCLES < 1) begin : g_bad_cycles
        $error("nvm_access_control: WRITE_CYCLES must be at least 1");
    end

    // Bus slave state
    logic awready_q, awready_d, wready_q, wready_d;
    logic aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic [7:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic do_wr, ar_take;

    // Register state
    ctrl_t ctrl_q, ctrl_d;
    logic [`NVM_ADDR_W-1:0] tptr_q, tptr_d;
    logic [`NVM_DATA_W-1:0] wbuf_q, wbuf_d, rbuf_q, rbuf_d;
    logic [2:0] stat_q, stat_d, en_q, en_d, ev;
    logic irq_q, irq_d;
    nvm_cmd_t cmd_q, cmd_d;
    logic erase_latch_q, erase_latch_d;
    logic wr_go, tmr_busy, tmr_done;

    always_comb begin
        aw_full_d = aw_full_q;
        aw_addr_d = aw_addr_q;
        w_full_d = w_full_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        if (s_axi_awvalid && awready_q) begin
            aw_full_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_full_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        do_wr = aw_full_q && w_full_q && !bvalid_q;
        if (do_wr) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
        end
        bvalid_d = do_wr || (bvalid_q && !s_axi_bready);
        bresp_d = bresp_q;
        if (do_wr) begin
            unique case (aw_addr_q)
                `NVM_CTRL_OFS, `NVM_TPTR_OFS, `NVM_WDATA_OFS, `NVM_IRQ_CLR_OFS, `NVM_IRQ_EN_OFS:
                    bresp_d = `NVM_RESP_OKAY;
                // Read-only data and status take a write as an error
                default: bresp_d = `NVM_RESP_SLVERR;
            endcase
        end
        awready_d = !aw_full_d && !bvalid_d;
        wready_d = !w_full_d && !bvalid_d;
    end

    always_comb begin
        ar_take = s_axi_arvalid && arready_q;
        rvalid_d = ar_take || (rvalid_q && !s_axi_rready);
        arready_d = !rvalid_d;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (ar_take) begin
            rresp_d = `NVM_RESP_OKAY;
            unique case (s_axi_araddr)
                `NVM_CTRL_OFS: rdata_d = {24'h000000, ctrl_q};
                `NVM_TPTR_OFS: rdata_d = 32'(tptr_q);
                `NVM_WDATA_OFS: rdata_d = 32'(wbuf_q);
                `NVM_RDATA_OFS: rdata_d = 32'(rbuf_q);
                `NVM_IRQ_STAT_OFS: rdata_d = 32'(stat_q);
                `NVM_IRQ_CLR_OFS: rdata_d = 32'h00000000;
                `NVM_IRQ_EN_OFS: rdata_d = 32'(en_q);
                default: begin
                    rdata_d = 32'h00000000;
                    rresp_d = `NVM_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `NVM_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `NVM_RESP_OKAY;
        end else begin
            awready_q <= awready_d;
            wready_q <= wready_d;
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            aw_addr_q <= aw_addr_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // Control register, memory command and interrupt state
    always_comb begin
        logic wr_ctrl, start_req, new_prog, new_cfg;
        wr_ctrl = do_wr && (aw_addr_q == `NVM_CTRL_OFS) && w_strb_q[0];
        start_req = 1'b0;
        new_prog = ctrl_q.program_or_eeprom_select;
        new_cfg = ctrl_q.config_space_select;
        ctrl_d = ctrl_q;
        tptr_d = tptr_q;
        wbuf_d = wbuf_q;
        rbuf_d = rbuf_q;
        en_d = en_q;
        erase_latch_d = erase_latch_q;
        ev = 3'h0;
        wr_go = 1'b0;

        if (ctrl_q.read_start) begin
            rbuf_d = nvm_rdata; // RULE_07
            ctrl_d.read_start = 1'b0; // RULE_07
            ev[`NVM_EV_RDONE] = 1'b1;
        end
        if (tmr_done) begin
            ctrl_d.write_start = 1'b0; // RULE_06
            ctrl_d.write_error_flag = 1'b0; // RULE_04
            ev[`NVM_EV_WDONE] = 1'b1;
        end

        if (do_wr && w_strb_q[0]) begin
            if (aw_addr_q == `NVM_TPTR_OFS) begin
                tptr_d = w_data_q[`NVM_ADDR_W-1:0];
            end
            if (aw_addr_q == `NVM_WDATA_OFS) begin
                wbuf_d = w_data_q[`NVM_DATA_W-1:0];
            end
            if (aw_addr_q == `NVM_IRQ_EN_OFS) begin
                en_d = w_data_q[2:0];
            end
        end
        if (wr_ctrl) begin
            new_prog = w_data_q[`NVM_BIT_PROG_SEL];
            new_cfg = w_data_q[`NVM_BIT_CFG_SEL];
            ctrl_d.program_or_eeprom_select = new_prog; // RULE_01
            ctrl_d.config_space_select = new_cfg; // RULE_02
            ctrl_d.row_erase_enable = w_data_q[`NVM_BIT_ROW_ERASE];
            ctrl_d.write_permit = w_data_q[`NVM_BIT_PERMIT];
            ctrl_d.write_error_flag = w_data_q[`NVM_BIT_WR_ERR];
            // Writing zero to a start bit does nothing
            start_req = w_data_q[`NVM_BIT_WSTART] && !ctrl_q.write_start && !tmr_busy;
            if (w_data_q[`NVM_BIT_RSTART] && !new_prog && !new_cfg) begin // RULE_08
                ctrl_d.read_start = 1'b1; // RULE_07
            end
        end
        if (start_req) begin
            // Permit is sampled as it stood before this write
            if (ctrl_q.write_permit) begin // RULE_05 RULE_09
                ctrl_d.write_start = 1'b1; // RULE_06
                erase_latch_d = w_data_q[`NVM_BIT_ROW_ERASE]; // RULE_03
                wr_go = 1'b1;
            end else begin
                ev[`NVM_EV_WERR] = 1'b1; // RULE_04
            end
        end

        if (warm_rst) begin
            // Selects and the error flag survive so software can trace the fault
            if (ctrl_q.write_start) begin
                ev[`NVM_EV_WERR] = 1'b1; // RULE_04
            end
            ctrl_d.write_start = 1'b0;
            ctrl_d.read_start = 1'b0;
            ctrl_d.write_permit = 1'b0;
            ctrl_d.row_erase_enable = 1'b0;
            ev[`NVM_EV_WDONE] = 1'b0;
            ev[`NVM_EV_RDONE] = 1'b0;
            wr_go = 1'b0;
        end
        if (ev[`NVM_EV_WERR]) begin
            ctrl_d.write_error_flag = 1'b1; // RULE_04
        end
        ctrl_d.unused = 1'b0;

        // Hardware set wins over a clear in the same cycle
        stat_d = stat_q;
        if (do_wr && (aw_addr_q == `NVM_IRQ_CLR_OFS) && w_strb_q[0]) begin
            stat_d = stat_q & ~w_data_q[2:0];
        end
        stat_d = stat_d | ev;
        irq_d = |(stat_d & en_d);

        cmd_d.program_or_eeprom_select = ctrl_d.program_or_eeprom_select; // RULE_01
        cmd_d.config_space_select = ctrl_d.config_space_select; // RULE_02
        cmd_d.erase = ctrl_d.write_start && erase_latch_d; // RULE_03
        cmd_d.write_active = ctrl_d.write_start; // RULE_05
        cmd_d.read_strobe = ctrl_d.read_start;
        cmd_d.addr = tptr_d;
        cmd_d.wdata = wbuf_d;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `NVM_CTRL_RST;
            tptr_q <= '0;
            wbuf_q <= '0;
            rbuf_q <= '0;
            stat_q <= 3'h0;
            en_q <= `NVM_IRQ_EN_RST;
            irq_q <= 1'b0;
            erase_latch_q <= 1'b0;
            cmd_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            tptr_q <= tptr_d;
            wbuf_q <= wbuf_d;
            rbuf_q <= rbuf_d;
            stat_q <= stat_d;
            en_q <= en_d;
            irq_q <= irq_d;
            erase_latch_q <= erase_latch_d;
            cmd_q <= cmd_d;
        end
    end

    // Aborted on warm reset, which leaves the array cycle cut short
    nvm_cycle_timer #(
        .CYCLES(WRITE_CYCLES)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .start(wr_go), // RULE_06
        .abort(warm_rst), // RULE_04
        .busy(tmr_busy),
        .done(tmr_done)
    );

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign nvm_cmd = cmd_q;
    assign irq = irq_q;

endmodule

//--- core/nvm_map.svh
`ifndef NVM_MAP_SVH
`define NVM_MAP_SVH

// Register byte offsets on the AXI4-Lite port
`define NVM_CTRL_OFS 8'h00
`define NVM_TPTR_OFS 8'h04
`define NVM_WDATA_OFS 8'h08
`define NVM_RDATA_OFS 8'h0C
`define NVM_IRQ_STAT_OFS 8'h10
`define NVM_IRQ_CLR_OFS 8'h14
`define NVM_IRQ_EN_OFS 8'h18

// Control register field positions
`define NVM_BIT_PROG_SEL 7
`define NVM_BIT_CFG_SEL 6
`define NVM_BIT_ROW_ERASE 4
`define NVM_BIT_WR_ERR 3
`define NVM_BIT_PERMIT 2
`define NVM_BIT_WSTART 1
`define NVM_BIT_RSTART 0

// Interrupt status bit positions
`define NVM_EV_WDONE 0
`define NVM_EV_WERR 1
`define NVM_EV_RDONE 2

// Reset values
`define NVM_CTRL_RST 8'h00
`define NVM_IRQ_EN_RST 3'h0

// Widths
`define NVM_ADDR_W 22
`define NVM_DATA_W 8

// Self-timed program cycle, least time
`define NVM_WRITE_TIME_NS 1000
`define NVM_CLK_PERIOD_NS 8
`define NVM_WRITE_CYCLES ((`NVM_WRITE_TIME_NS + `NVM_CLK_PERIOD_NS - 1) / `NVM_CLK_PERIOD_NS)

// AXI responses
`define NVM_RESP_OKAY 2'b00
`define NVM_RESP_SLVERR 2'b10

`endif

//--- core/nvm_pkg.sv
package nvm_pkg;

    `include "nvm_map.svh"

    typedef struct packed {
        logic program_or_eeprom_select;
        logic config_space_select;
        logic unused;
        logic row_erase_enable;
        logic write_error_flag;
        logic write_permit;
        logic write_start;
        logic read_start;
    } ctrl_t;

    typedef struct packed {
        logic program_or_eeprom_select;
        logic config_space_select;
        logic erase;
        logic write_active;
        logic read_strobe;
        logic [`NVM_ADDR_W-1:0] addr;
        logic [`NVM_DATA_W-1:0] wdata;
    } nvm_cmd_t;

    typedef enum logic {
        TMR_IDLE,
        TMR_RUN
    } tmr_state_t;

endpackage

//--- core/nvm_cycle_timer.sv
`timescale 1ns/1ps

module nvm_cycle_timer
    import nvm_pkg::*;
#(
    parameter int CYCLES = 125
) (
    input wire logic ref_clk, // System clock
    input wire logic rst_b, // Power-on reset
    input wire logic start, // Begin a self-timed cycle
    input wire logic abort, // Cut the cycle short
    output logic busy, // Cycle running
    output logic done // Cycle finished normally
);

    localparam int CW = $clog2(CYCLES + 1);

    if (CYCLES < 1) begin : g_bad_cycles
        $error("nvm_cycle_timer: CYCLES must be at least 1");
    end

    tmr_state_t state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic done_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        unique case (state_q)
            TMR_IDLE: begin
                if (start && !abort) begin
                    state_d = TMR_RUN;
                    cnt_d = CW'(CYCLES - 1);
                end
            end
            TMR_RUN: begin
                if (abort) begin
                    state_d = TMR_IDLE;
                end else if (cnt_q == '0) begin
                    state_d = TMR_IDLE;
                    done_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= TMR_IDLE;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    assign busy = (state_q == TMR_RUN);
    // Unregistered so the owner's command drops after exactly CYCLES cycles
    assign done = done_d;

endmodule

//--- tb/nvm_array_model.sv
`timescale 1ns/1ps

module nvm_array_model
    import nvm_pkg::*;
(
    input wire logic ref_clk, // System clock
    input wire nvm_cmd_t nvm_cmd, // Command from the block
    output logic [7:0] nvm_rdata // Array read data
);
    logic [7:0] junk_q = 8'h00;

    // Outside a read the lines carry a moving pattern, never the last value
    always_ff @(posedge ref_clk) begin
        junk_q <= junk_q + 8'h3B;
    end

    assign nvm_rdata = nvm_cmd.read_strobe ? (nvm_cmd.addr[7:0] ^ 8'h5A) : junk_q;
endmodule

//--- tb/nvm_access_control_properties.sv
`timescale 1ns/1ps

module nvm_access_control_properties
    import nvm_pkg::*;
#(
    parameter int WRITE_CYCLES = 4
) (
    input wire logic ref_clk, // Clock
    input wire logic rst_b, // Async reset
    input wire logic warm_rst, // Device reset
    input wire logic s_axi_awvalid, // AW valid
    input wire logic s_axi_awready, // AW ready
    input wire logic s_axi_wvalid, // W valid
    input wire logic s_axi_wready, // W ready
    input wire logic [1:0] s_axi_bresp, // B response
    input wire logic s_axi_bvalid, // B valid
    input wire logic s_axi_bready, // B ready
    input wire logic s_axi_arvalid, // AR valid
    input wire logic s_axi_arready, // AR ready
    input wire logic [31:0] s_axi_rdata, // R data
    input wire logic s_axi_rvalid, // R valid
    input wire logic s_axi_rready, // R ready
    input wire nvm_cmd_t nvm_cmd // Array command
);
    logic [15:0] run_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            run_q <= 16'h0000;
        end else begin
            run_q <= nvm_cmd.write_active ? run_q + 16'h0001 : 16'h0000;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    AST_READ_PULSE: assert property (nvm_cmd.read_strobe |=> !nvm_cmd.read_strobe)
        else $error("read strobe longer than one cycle");
    AST_READ_SEL: assert property (nvm_cmd.read_strobe |-> !nvm_cmd.program_or_eeprom_select && !nvm_cmd.config_space_select)
        else $error("read strobe with a select bit set");
    AST_WRITE_LEN: assert property ($fell(nvm_cmd.write_active) && !$past(warm_rst) |-> run_q == WRITE_CYCLES)
        else $error("write cycle length wrong");
    AST_WRITE_MAX: assert property (run_q <= WRITE_CYCLES)
        else $error("write cycle overran");
    AST_ABORT: assert property (warm_rst && nvm_cmd.write_active |=> !nvm_cmd.write_active)
        else $error("write not cut short by reset");
    AST_ERASE_HELD: assert property (nvm_cmd.write_active && $past(nvm_cmd.write_active) |-> $stable(nvm_cmd.erase) && $stable(nvm_cmd.addr))
        else $error("erase or address moved during a cycle");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read data late");
endmodule

bind nvm_access_control nvm_access_control_properties #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (.ref_clk(ref_clk),
    .rst_b(rst_b), .warm_rst(warm_rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .nvm_cmd(nvm_cmd));

//--- tb/nvm_access_control_test.sv
`timescale 1ns/1ps
`include "nvm_map.svh"

module nvm_access_control_test
    import nvm_pkg::*;
;
    localparam int WC = 20;
    localparam logic [1:0] OK = `NVM_RESP_OKAY;
    localparam logic [1:0] ERR = `NVM_RESP_SLVERR;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic warm_rst = 1'b0;
    logic [7:0] aw_a = 8'h00;
    logic [7:0] ar_a = 8'h00;
    logic [31:0] w_d = 32'h0;
    logic aw_v = 1'b0;
    logic w_v = 1'b0;
    logic b_r = 1'b0;
    logic ar_v = 1'b0;
    logic r_r = 1'b0;
    logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq;
    logic [1:0] b_resp, r_resp;
    logic [31:0] r_d;
    logic [7:0] arr_d;
    logic [21:0] tp;
    logic [7:0] wd;
    nvm_cmd_t cmd;
    int fail_count = 0;
    int compares = 0;
    int seed = 72;
    int strobes = 0;
    int stat_m = 0;
    int en_m = 0;

    always #4 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (cmd.read_strobe === 1'b1) begin
            strobes++;
        end
    end

    nvm_access_control #(.WRITE_CYCLES(WC)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .warm_rst(warm_rst),
        .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
        .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
        .s_axi_rvalid(r_v), .s_axi_rready(r_r), .nvm_cmd(cmd), .nvm_rdata(arr_d), .irq(irq));

    nvm_array_model u_array (.ref_clk(ref_clk), .nvm_cmd(cmd), .nvm_rdata(arr_d));

    task close_out;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task hang;
        fail_count++;
        close_out;
    endtask

    task cmp_data(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected response at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Ready is raised late on purpose so the held response is seen
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge ref_clk);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            if (aw_v && aw_rdy) aw_v <= 1'b0;
            if (w_v && w_rdy) w_v <= 1'b0;
            if (b_r && b_v) break;
            if (b_v) b_r <= 1'b1;
        end
        if (n == 40) hang;
        b_r <= 1'b0;
        cmp_resp(b_resp, er);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge ref_clk);
        ar_a <= a;
        ar_v <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            if (ar_v && ar_rdy) ar_v <= 1'b0;
            if (r_r && r_v) break;
            if (r_v) r_r <= 1'b1;
        end
        if (n == 40) hang;
        r_r <= 1'b0;
        cmp_data(r_d, ed);
        cmp_resp(r_resp, er);
    endtask

    task chk_irq;
        #1 cmp_data({31'h0, irq}, {31'h0, (stat_m & en_m) != 0});
    endtask

    initial begin
        int n;
        int s0;
        logic [7:0] v;
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd(`NVM_CTRL_OFS, 32'h0, OK);
        rd(`NVM_IRQ_EN_OFS, 32'h0, OK);
        rd(`NVM_IRQ_STAT_OFS, 32'h0, OK);
        wr(8'h1C, 32'h1, ERR);
        rd(8'h1C, 32'h0, ERR);
        wr(`NVM_IRQ_STAT_OFS, 32'h7, ERR);
        rd(`NVM_IRQ_CLR_OFS, 32'h0, OK);
        wr(`NVM_CTRL_OFS, 32'h02, OK);
        stat_m = 2;
        #1 cmp_data({31'h0, cmd.write_active}, 32'h0);
        rd(`NVM_CTRL_OFS, 32'h08, OK);
        rd(`NVM_IRQ_STAT_OFS, stat_m, OK);
        wr(`NVM_IRQ_EN_OFS, 32'h7, OK);
        en_m = 7;
        chk_irq;
        wr(`NVM_IRQ_EN_OFS, 32'h1, OK);
        en_m = 1;
        chk_irq;
        wr(`NVM_IRQ_CLR_OFS, 32'h7, OK);
        stat_m = 0;
        rd(`NVM_IRQ_STAT_OFS, stat_m, OK);
        tp = 22'($random(seed));
        wd = 8'($random(seed));
        wr(`NVM_TPTR_OFS, {10'h0, tp}, OK);
        wr(`NVM_WDATA_OFS, {24'h0, wd}, OK);
        wr(`NVM_CTRL_OFS, 32'h14, OK);
        wr(`NVM_CTRL_OFS, 32'h16, OK);
        #1 cmp_data({cmd.write_active, cmd.erase, cmd.addr, cmd.wdata}, {2'b11, tp, wd});
        wr(`NVM_CTRL_OFS, 32'h14, OK);
        rd(`NVM_CTRL_OFS, 32'h16, OK);
        for (n = 0; n < 40 && cmd.write_active === 1'b1; n++) @(posedge ref_clk);
        if (n == 40) hang;
        stat_m = 1;
        rd(`NVM_CTRL_OFS, 32'h14, OK);
        rd(`NVM_IRQ_STAT_OFS, stat_m, OK);
        chk_irq;
        wr(`NVM_CTRL_OFS, 32'h84, OK);
        wr(`NVM_CTRL_OFS, 32'h86, OK);
        #1 cmp_data({30'h0, cmd.program_or_eeprom_select, cmd.erase}, 32'h2);
        @(posedge ref_clk);
        warm_rst <= 1'b1;
        @(posedge ref_clk);
        warm_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        cmp_data({31'h0, cmd.write_active}, 32'h0);
        stat_m = 3;
        rd(`NVM_CTRL_OFS, 32'h88, OK);
        rd(`NVM_IRQ_STAT_OFS, stat_m, OK);
        wr(`NVM_CTRL_OFS, 32'h40, OK);
        #1 cmp_data({31'h0, cmd.config_space_select}, 32'h1);
        wr(`NVM_IRQ_CLR_OFS, 32'h7, OK);
        // Refused reads first, the allowed one last
        for (n = 0; n < 4; n++) begin
            v = (n == 3) ? 8'h01 : {2'(n + 1), 6'h01};
            s0 = strobes;
            wr(`NVM_CTRL_OFS, {24'h0, v}, OK);
            rd(`NVM_CTRL_OFS, {24'h0, v & 8'hC0}, OK);
            cmp_data(strobes - s0, (n == 3) ? 1 : 0);
        end
        stat_m = 4;
        rd(`NVM_RDATA_OFS, {24'h0, tp[7:0] ^ 8'h5A}, OK);
        rd(`NVM_IRQ_STAT_OFS, stat_m, OK);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd(`NVM_CTRL_OFS, 32'h0, OK);
        rd(`NVM_IRQ_STAT_OFS, 32'h0, OK);
        close_out;
    end
endmodule
